//--- hw/pdlp_host.sv
// Purpose: controller that writes and reads back the converter code
// Assumes: user holds request data stable while busy is high
// Notes: one access at a time, request taken only in idle
`timescale 1ns/1ps
`default_nettype none
module pdlp_host
    import pdlp_pkg::*;
#(
    parameter int DATA_W = PDLP_DATA_W
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // user request side
    input wire logic req_valid_in,
    input wire logic req_read_in,
    input wire logic [DATA_W-1:0] req_code_in,
    output logic req_ready_out,
    output logic done_out,
    output logic [DATA_W-1:0] rd_code_out,
    // converter pins
    output logic cs_n_out,
    output logic rw_out,
    output logic [DATA_W-1:0] parallel_data_bus_out,
    output logic parallel_data_bus_oe_n_out,
    input wire logic [DATA_W-1:0] parallel_data_bus_in
);
    pdlp_state_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [DATA_W-1:0] code_reg;
    logic [DATA_W-1:0] rd_code_reg;
    logic done_reg;
    logic [DATA_W-1:0] bus_sync;
    logic cnt_zero;
    logic take_req;
    logic cs_n_reg, rw_reg, oe_n_reg;
    logic cs_n_next, rw_next, oe_n_next;

    // bus word crosses into clk_in domain
    pdlp_sync #(.WIDTH(DATA_W)) u_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .async_in(parallel_data_bus_in),
        .sync_out(bus_sync)
    );

    // handshake decode
    assign cnt_zero = (cnt_reg == PDLP_CNT_ZERO);
    assign take_req = (state_reg == PDLP_IDLE) && req_valid_in;
    assign req_ready_out = (state_reg == PDLP_IDLE);

    // next state and counter
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_zero ? cnt_reg : cnt_reg - 4'h1;
        unique case (state_reg)
            PDLP_IDLE:
            begin
                if (take_req && req_read_in)
                begin
                    state_next = PDLP_RD_SETUP; // RL5
                    cnt_next = 4'(PDLP_RW_SETUP_CYC - 1);
                end
                else if (take_req)
                begin
                    state_next = PDLP_WR_LOW; // RL2
                    cnt_next = 4'(PDLP_CS_LOW_CYC - 1);
                end
            end
            PDLP_WR_LOW:
            begin
                if (cnt_zero)
                begin
                    state_next = PDLP_RECOVER; // RL4
                    cnt_next = 4'(PDLP_CS_HIGH_CYC - 1);
                end
            end
            PDLP_RD_SETUP:
            begin
                if (cnt_zero)
                begin
                    state_next = PDLP_RD_LOW;
                    cnt_next = 4'(PDLP_ACCESS_CYC - 1);
                end
            end
            PDLP_RD_LOW:
            begin
                if (cnt_zero)
                begin
                    state_next = PDLP_RECOVER;
                    cnt_next = 4'(PDLP_RELINQ_CYC - 1);
                end
            end
            PDLP_RECOVER:
            begin
                if (cnt_zero)
                begin
                    state_next = PDLP_IDLE;
                end
            end
            default:
            begin
                state_next = PDLP_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            state_reg <= PDLP_IDLE;
            cnt_reg <= PDLP_CNT_ZERO;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // capture write word, unsigned straight binary, bit 11 msb
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            code_reg <= PDLP_CODE_RESET;
        end
        else if (take_req && !req_read_in)
        begin
            code_reg <= req_code_in; // RL1 RL6 RL7
        end
    end

    // read sample at end of select low, done pulse
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            rd_code_reg <= PDLP_CODE_RESET;
            done_reg <= 1'b0;
        end
        else
        begin
            done_reg <= (state_reg == PDLP_RECOVER) && cnt_zero;
            if (state_reg == PDLP_RD_LOW && cnt_zero)
            begin
                rd_code_reg <= bus_sync; // RL5
            end
        end
    end

    // pin levels decoded from the next state, select active low
    assign cs_n_next = !(state_next == PDLP_WR_LOW ||
                         state_next == PDLP_RD_LOW); // RL8 RL4
    // read/write high only around reads
    assign rw_next = (state_next == PDLP_RD_SETUP ||
                      state_next == PDLP_RD_LOW); // RL8
    // host drives the bus only during write select
    assign oe_n_next = !(state_next == PDLP_WR_LOW); // RL2 RL9

    // pins from flops: a decode glitch on select would load the converter
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            cs_n_reg <= PDLP_CS_N_RESET;
            rw_reg <= PDLP_RW_RESET;
            oe_n_reg <= PDLP_OE_N_RESET;
        end
        else
        begin
            cs_n_reg <= cs_n_next;
            rw_reg <= rw_next;
            oe_n_reg <= oe_n_next;
        end
    end

    // pin outputs, same cycle timing as the state register
    assign cs_n_out = cs_n_reg;
    assign rw_out = rw_reg;
    assign parallel_data_bus_oe_n_out = oe_n_reg;
    assign parallel_data_bus_out = code_reg;
    assign rd_code_out = rd_code_reg;
    assign done_out = done_reg;

    // write keeps select low the full low time, rising edge follows
    property p_wr_cs_low;
        @(posedge clk_in) disable iff (reset_in)
        $rose(state_reg == PDLP_WR_LOW) |->
            (!cs_n_out && !rw_out)[*2] ##1 cs_n_out;
    endproperty
    a_wr_cs_low: assert property (p_wr_cs_low) // RL4
        else $error("write select pulse wrong");

    property p_no_contention;
        @(posedge clk_in) disable iff (reset_in)
        !parallel_data_bus_oe_n_out |-> !cs_n_out && !rw_out;
    endproperty
    a_no_contention: assert property (p_no_contention) // RL9
        else $error("host drives bus outside a write");

    property p_rd_setup;
        @(posedge clk_in) disable iff (reset_in)
        $fell(cs_n_out) && rw_out |-> $past(rw_out);
    endproperty
    a_rd_setup: assert property (p_rd_setup) // RL5
        else $error("read select without rw setup");

    property p_wr_data;
        @(posedge clk_in) disable iff (reset_in)
        take_req && !req_read_in |=>
            parallel_data_bus_out == $past(req_code_in);
    endproperty
    a_wr_data: assert property (p_wr_data) // RL1
        else $error("write word not presented");

    property p_rw_stable;
        @(posedge clk_in) disable iff (reset_in)
        !cs_n_out && !$fell(cs_n_out) |-> $stable(rw_out);
    endproperty
    a_rw_stable: assert property (p_rw_stable) // RL8
        else $error("rw changed while selected");

    property p_done;
        @(posedge clk_in) disable iff (reset_in)
        $rose(cs_n_out) |-> ##[1:3] done_out;
    endproperty
    a_done: assert property (p_done) // RL2
        else $error("done missing after access");

    // read word changes only after the last cycle of a read select
    property p_rd_hold;
        @(posedge clk_in) disable iff (reset_in)
        !$past(state_reg == PDLP_RD_LOW && cnt_zero) |->
            $stable(rd_code_out);
    endproperty
    a_rd_hold: assert property (p_rd_hold) // RL5
        else $error("read word changed outside a read");
endmodule // pdlp_host
`default_nettype wire

//--- hw/pdlp_sync.sv
// Purpose: two-stage synchroniser for the returned bus word
// Assumes: input is asynchronous to clk_in
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module pdlp_sync #(
    parameter int WIDTH = 12
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // two flops per bit
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // pdlp_sync
`default_nettype wire

//--- shared/pdlp_pkg.sv
// Purpose: constants for the parallel converter load port controller
// Assumes: 200 MHz clk_in, 5 ns period
// Notes: timings are the slower supply range figures
// Functional notes
// RL1: every transfer carries one 12-bit word on a shared two-way bus.
// RL2: a write drives select low and read/write low while the word is shown.
// RL3: the device moves the word into its converter register on select rise.
// RL4: every write needs a falling then a rising edge on select.
// RL5: a read holds read/write high and select low; device drives the bus.
// RL6: the code is unsigned straight binary over a full scale of 4096.
// RL7: bus bits run 11 down to 0 with bit 11 the most significant.
// RL8: select is active low; read/write low writes and high reads.
// RL9: the device drives the bus only while selected for a read.
package pdlp_pkg;
    localparam int PDLP_CLK_PERIOD_NS = 5;
    localparam int PDLP_DATA_W = 12;
    localparam int PDLP_FULL_SCALE = 4096;
    // select low time on a write
    localparam int PDLP_CS_LOW_NS = 10;
    // select high time between accesses
    localparam int PDLP_CS_HIGH_NS = 9;
    // read/write high before select low
    localparam int PDLP_RW_SETUP_NS = 5;
    // worst data access time
    localparam int PDLP_ACCESS_NS = 40;
    // worst bus relinquish time
    localparam int PDLP_RELINQ_NS = 10;
    // least times round up
    localparam int PDLP_CS_LOW_CYC =
        (PDLP_CS_LOW_NS + PDLP_CLK_PERIOD_NS - 1) / PDLP_CLK_PERIOD_NS;
    localparam int PDLP_CS_HIGH_CYC =
        (PDLP_CS_HIGH_NS + PDLP_CLK_PERIOD_NS - 1) / PDLP_CLK_PERIOD_NS;
    localparam int PDLP_RW_SETUP_CYC =
        (PDLP_RW_SETUP_NS + PDLP_CLK_PERIOD_NS - 1) / PDLP_CLK_PERIOD_NS;
    // access, two synchroniser stages and one spare cycle, so the
    // first stage never samples on the edge where the data settles
    localparam int PDLP_ACCESS_CYC =
        (PDLP_ACCESS_NS + PDLP_CLK_PERIOD_NS - 1) / PDLP_CLK_PERIOD_NS + 3;
    localparam int PDLP_RELINQ_CYC =
        (PDLP_RELINQ_NS + PDLP_CLK_PERIOD_NS - 1) / PDLP_CLK_PERIOD_NS;
    localparam logic [3:0] PDLP_CNT_ZERO = 4'h0;
    localparam logic [11:0] PDLP_CODE_RESET = 12'h000;
    // pin levels during and after reset: deselected, write, released
    localparam logic PDLP_CS_N_RESET = 1'h1;
    localparam logic PDLP_RW_RESET = 1'h0;
    localparam logic PDLP_OE_N_RESET = 1'h1;

    typedef enum logic [2:0] {
        PDLP_IDLE = 3'b000,
        PDLP_WR_LOW = 3'b001,
        PDLP_RD_SETUP = 3'b010,
        PDLP_RD_LOW = 3'b011,
        PDLP_RECOVER = 3'b100
    } pdlp_state_e;
endpackage

//--- testbench/pdlp_dev_model.sv
// Purpose: behavioural model of the converter parallel port
// Assumes: host keeps select and read/write ordering
// Notes: a released bus shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module pdlp_dev_model
    import pdlp_pkg::*;
(
    // host pins and the bench access time
    input wire logic cs_n_in,
    input wire logic rw_in,
    input wire logic [PDLP_DATA_W-1:0] host_data_in,
    input wire logic host_oe_n_in,
    input wire logic [7:0] access_ns_in,
    // resolved bus and state
    output logic [PDLP_DATA_W-1:0] bus_level_out,
    output logic dev_drive_out,
    output logic [PDLP_DATA_W-1:0] dac_code_out
);
    logic [PDLP_DATA_W-1:0] in_reg;
    logic [PDLP_DATA_W-1:0] dev_data;
    logic [PDLP_DATA_W-1:0] last_reg;
    logic wr_sel;
    // power-up contents
    initial
    begin
        dac_code_out = PDLP_CODE_RESET;
        dev_drive_out = 1'b0;
        last_reg = 12'h000;
        wr_sel = 1'b0;
    end
    // input register follows the bus while selected for a write
    always @*
        if (!cs_n_in && !rw_in && !host_oe_n_in)
            in_reg = bus_level_out;
    // access kind fixed at select fall; rw may drop with the select rise
    always @(negedge cs_n_in)
        wr_sel = !rw_in;
    // only the select rise of a write moves the word on
    always @(posedge cs_n_in)
        if (wr_sel)
            dac_code_out = in_reg;
    // readback after the access time
    always @(negedge cs_n_in)
        if (rw_in)
        begin
            #(access_ns_in);
            dev_data = dac_code_out;
            dev_drive_out = !cs_n_in && rw_in;
        end
    // release after the relinquish time
    always @(posedge cs_n_in or negedge rw_in)
        dev_drive_out <= #(PDLP_RELINQ_NS) 1'b0;
    // wire level from both parties
    always @*
    begin
        if (!host_oe_n_in)
            last_reg = host_data_in;
        else if (dev_drive_out)
            last_reg = dev_data;
        bus_level_out = (!host_oe_n_in || dev_drive_out) ? last_reg : ~last_reg;
    end
endmodule // pdlp_dev_model
`default_nettype wire

//--- testbench/pdlp_host_tb.sv
// Purpose: self-checking bench for the converter port controller
// Assumes: model stands in for the converter
// Notes: expected results queued by the driver, checked on done
`timescale 1ns/1ps
`default_nettype none
module pdlp_host_tb;
    import pdlp_pkg::*;
    logic clk_in, reset_in, req_valid_in, req_read_in, req_ready_out;
    logic done_out, cs_n_out, rw_out, oe_n, dev_drive;
    logic [11:0] req_code_in, rd_code_out, bus_out, bus_level, dac_code, w;
    logic [7:0] access_ns;
    logic [12:0] exp_e;
    logic [12:0] exp_q[$];
    logic [11:0] corners[5] = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'h801};
    int fails, total_checks, i, n;
    pdlp_host dut (.clk_in(clk_in), .reset_in(reset_in),
        .req_valid_in(req_valid_in), .req_read_in(req_read_in),
        .req_code_in(req_code_in), .req_ready_out(req_ready_out),
        .done_out(done_out), .rd_code_out(rd_code_out), .cs_n_out(cs_n_out),
        .rw_out(rw_out), .parallel_data_bus_out(bus_out),
        .parallel_data_bus_oe_n_out(oe_n), .parallel_data_bus_in(bus_level));
    pdlp_dev_model model (.cs_n_in(cs_n_out), .rw_in(rw_out),
        .host_data_in(bus_out), .host_oe_n_in(oe_n),
        .access_ns_in(access_ns), .bus_level_out(bus_level),
        .dev_drive_out(dev_drive), .dac_code_out(dac_code));
    // shared mismatch report
    task automatic check_eq(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_rd(input logic [11:0] got, input logic [11:0] exp);
        check_eq(got, exp);
    endtask
    task automatic cmp_dac(input logic [11:0] got, input logic [11:0] exp);
        check_eq(got, exp);
    endtask
    task automatic cmp_pin(input logic got, input logic exp);
        check_eq({11'h000, got}, {11'h000, exp});
    endtask
    task automatic report_and_stop();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // one request, expected result noted
    task automatic access(input logic rd, input logic [11:0] code);
        n = 0;
        while (req_ready_out !== 1'b1 && n < 100)
        begin
            @(negedge clk_in);
            n++;
        end
        if (req_ready_out !== 1'b1)
            fails++;
        req_valid_in = 1'b1;
        req_read_in = rd;
        req_code_in = code;
        exp_q.push_back({rd, code});
        @(negedge clk_in);
        req_valid_in = 1'b0;
    endtask
    // clock
    initial
    begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // result and pin watcher
    always @(negedge clk_in)
    begin
        if (!reset_in)
        begin
            cmp_pin(oe_n, cs_n_out | rw_out);
            cmp_pin(dev_drive & !oe_n, 1'b0);
        end
        if (done_out === 1'b1 && exp_q.size() > 0)
        begin
            exp_e = exp_q.pop_front();
            if (exp_e[12])
                cmp_rd(rd_code_out, exp_e[11:0]);
            else
                cmp_dac(dac_code, exp_e[11:0]);
        end
    end
    // watchdog
    initial
    begin
        #20000;
        fails++;
        report_and_stop();
    end
    // main sequence
    initial
    begin
        reset_in = 1'b1;
        req_valid_in = 1'b0;
        req_read_in = 1'b0;
        req_code_in = 12'h000;
        access_ns = 8'h05;
        fails = 0;
        total_checks = 0;
        void'($urandom(95));
        repeat (10) @(negedge clk_in);
        reset_in = 1'b0;
        access(1'b1, PDLP_CODE_RESET);
        for (i = 0; i < 6; i++)
        begin
            access_ns = i[0] ? 8'h28 : 8'h05;
            w = 12'($urandom);
            access(1'b0, w);
            w = (i < 5) ? corners[i] : 12'($urandom);
            access(1'b0, w);
            access(1'b1, w);
            access(1'b1, w);
        end
        n = 0;
        while (exp_q.size() > 0 && n < 100)
        begin
            @(negedge clk_in);
            n++;
        end
        check_eq(12'(exp_q.size()), 12'h000);
        report_and_stop();
    end
endmodule // pdlp_host_tb
`default_nettype wire
